// file: hdl/ptu_periodic_tick_unit.v
// Periodic tick unit: divider control, tick flag and Avalon register slave
//
// Functional notes
// RULE_01 - Enable clear holds divider at zero
// RULE_02 - Enable set starts counting source clock edges
// RULE_03 - Selected tap rollover sets flag; not writable
// RULE_04 - Flag and irq enable raise CPU request
// RULE_05 - First flag after enable at half period
// RULE_06 - Later flags exactly one period apart
// RULE_07 - Rate codes divide 32768 down to 8
// RULE_08 - Fifteen stages, eight selectable taps
// RULE_09 - Divider driven by crystal clock, not bus
// RULE_10 - Acknowledge reads zero; one clears flag
// RULE_11 - Irq enable read/write, cleared by reset
// RULE_12 - Enable read/write, reset clears, counter zeroed
// RULE_13 - Software keeps rate fixed while enabled
// RULE_14 - Wait mode keeps counting; register locked
// RULE_15 - Stop mode runs only with oscillator kept
// RULE_16 - Stop without oscillator keeps unit inactive
// RULE_17 - Stop mode blocks register access
// RULE_18 - Flag sticky until acknowledged; request held
//
// The address map and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "ptu_regs.vh"

module ptu_periodic_tick_unit #(
    parameter STAGES = `PTU_STAGES
) (
    input  wire                   clk_sys,
    input  wire                   reset,
    input  wire [`PTU_ADDR_W-1:0] avs_address,
    input  wire                   avs_read,
    input  wire                   avs_write,
    input  wire [31:0]            avs_writedata,
    input  wire [3:0]             avs_byteenable,
    output wire [31:0]            avs_readdata,
    output wire                   avs_waitrequest,
    input  wire                   crystal_input,
    input  wire                   wait_mode,
    input  wire                   stop_mode,
    input  wire                   oscillator_run_in_stop,
    output wire                   tick_irq_request,
    output wire                   stop_wakeup,
    output wire                   irq
);

    // Rate code to tap stage; the tap rises after half the division
    function [`PTU_TAP_W-1:0] tap_index;
        input [2:0] rate;
        begin
            case (rate)
                3'h0:    tap_index = `PTU_TAP_R0;
                3'h1:    tap_index = `PTU_TAP_R1;
                3'h2:    tap_index = `PTU_TAP_R2;
                3'h3:    tap_index = `PTU_TAP_R3;
                3'h4:    tap_index = `PTU_TAP_R4;
                3'h5:    tap_index = `PTU_TAP_R5;
                3'h6:    tap_index = `PTU_TAP_R6;
                default: tap_index = `PTU_TAP_R7;
            endcase
        end
    endfunction

    // Pack control fields into the readable byte
    function [7:0] control_image;
        input       flag;
        input [2:0] rate;
        input       irq_en;
        input       enable;
        begin
            control_image                                  = 8'h00;
            control_image[`PTU_BIT_FLAG]                   = flag;
            control_image[`PTU_RATE_MSB:`PTU_RATE_LSB]     = rate;
            control_image[`PTU_BIT_IRQ_EN]                 = irq_en;
            control_image[`PTU_BIT_ENABLE]                 = enable;
            control_image[`PTU_BIT_ACK]                    = 1'b0;
        end
    endfunction

    // Control state
    reg                   enable_reg;
    reg                   enable_next;
    reg                   irq_en_reg;
    reg                   irq_en_next;
    reg  [2:0]            rate_reg;
    reg  [2:0]            rate_next;
    reg                   flag_reg;
    reg                   flag_next;

    // Interrupt status and mask
    reg  [`PTU_ST_W-1:0]  status_reg;
    reg  [`PTU_ST_W-1:0]  status_next;
    reg  [`PTU_ST_W-1:0]  mask_reg;
    reg  [`PTU_ST_W-1:0]  mask_next;

    // Bus handshake and read data
    reg                   resp_reg;
    wire                  resp_next;
    reg  [31:0]           rdata_reg;
    reg  [31:0]           rdata_next;

    // Source clock edge detection
    reg                   src_prev_reg;
    wire                  src_rise;

    // Decoded strobes
    wire                  bus_req;
    wire                  bus_fire;
    wire                  locked;
    wire                  wr_fire;
    wire                  blocked_fire;
    wire                  sel_control;
    wire                  sel_status;
    wire                  sel_mask;
    wire                  sel_count;
    wire [7:0]            wbyte;
    wire                  ack_write;
    wire                  osc_alive;
    wire                  div_run;
    wire                  div_clear;
    wire                  tap_event;
    wire [STAGES-1:0]     div_count;
    wire [`PTU_ST_W-1:0]  status_set;
    wire [`PTU_ST_W-1:0]  status_clr;

    // Previous crystal level; input is already synchronous
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            src_prev_reg <= 1'b0;
        end else begin
            src_prev_reg <= crystal_input;
        end
    end

    // Only crystal edges advance the chain, never the bus clock
    assign src_rise = crystal_input & ~src_prev_reg; // RULE_09

    // Without the oscillator kept alive in stop, the chain freezes
    assign osc_alive = ~stop_mode | oscillator_run_in_stop; // RULE_15 RULE_16

    // Wait mode leaves the chain running
    assign div_run   = enable_reg & src_rise & osc_alive; // RULE_02 RULE_14

    // Disabled unit keeps every stage at zero
    assign div_clear = ~enable_reg; // RULE_01

    // Divider chain, tap picked by rate code
    ptu_divider #(
        .STAGES (STAGES),
        .TAP_W  (`PTU_TAP_W)
    ) u_divider (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .run       (div_run),
        .clear     (div_clear),
        .tap_sel   (tap_index(rate_reg)), // RULE_07 RULE_08
        .count     (div_count),
        .tap_event (tap_event)
    );
    // Counting from zero, tap bit rises at half period, then every
    // full period; hence first tick early, later ticks exact
    // RULE_05 RULE_06

    // Two-phase slave: request seen, then answered next cycle
    assign bus_req         = avs_read | avs_write;
    assign resp_next       = bus_req & ~resp_reg;
    assign avs_waitrequest = bus_req & ~resp_reg;
    assign bus_fire        = bus_req & resp_reg;

    // Handshake phase
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            resp_reg <= 1'b0;
        end else begin
            resp_reg <= resp_next;
        end
    end

    // Low-power modes shut the CPU out of the register
    assign locked       = wait_mode | stop_mode; // RULE_14 RULE_17
    assign blocked_fire = bus_fire & locked;

    // Address decode on byte offsets
    assign sel_control = (avs_address == `PTU_OFS_CONTROL);
    assign sel_status  = (avs_address == `PTU_OFS_STATUS);
    assign sel_mask    = (avs_address == `PTU_OFS_MASK);
    assign sel_count   = (avs_address == `PTU_OFS_COUNT);

    // All writable fields live in byte lane 0
    assign wr_fire = avs_write & bus_fire & ~locked & avs_byteenable[0];
    assign wbyte   = avs_writedata[7:0];

    // Acknowledge is a pure write action
    assign ack_write = wr_fire & sel_control & wbyte[`PTU_BIT_ACK]; // RULE_10

    // Control field updates
    always @* begin
        enable_next = enable_reg;
        irq_en_next = irq_en_reg;
        rate_next   = rate_reg;
        if (wr_fire && sel_control) begin
            enable_next = wbyte[`PTU_BIT_ENABLE]; // RULE_12
            irq_en_next = wbyte[`PTU_BIT_IRQ_EN]; // RULE_11
            // Rate is taken as written; changing it while running is
            // the caller's fault and may skip or double a tick
            rate_next   = wbyte[`PTU_RATE_MSB:`PTU_RATE_LSB]; // RULE_13
        end
    end

    // Flag: hardware set beats acknowledge in the same cycle
    always @* begin
        flag_next = flag_reg;
        if (tap_event) begin
            flag_next = 1'b1; // RULE_03 RULE_18
        end else if (ack_write) begin
            flag_next = 1'b0; // RULE_10
        end
    end

    // Control registers
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            enable_reg <= 1'b0; // RULE_12
            irq_en_reg <= 1'b0; // RULE_11
            rate_reg   <= 3'h0;
            flag_reg   <= 1'b0;
        end else begin
            enable_reg <= enable_next;
            irq_en_reg <= irq_en_next;
            rate_reg   <= rate_next;
            flag_reg   <= flag_next;
        end
    end

    // Events: tick, locked access, tick while flag still pending
    assign status_set[`PTU_ST_TICK]    = tap_event;
    assign status_set[`PTU_ST_BLOCKED] = blocked_fire;
    assign status_set[`PTU_ST_MISSED]  = tap_event & flag_reg;

    // Write one to clear; zeros leave bits alone
    assign status_clr = (wr_fire & sel_status) ?
                        wbyte[`PTU_ST_W-1:0] : {`PTU_ST_W{1'b0}};

    // Sticky status, set wins over clear
    always @* begin
        status_next = (status_reg & ~status_clr) | status_set;
    end

    // Mask register
    always @* begin
        mask_next = mask_reg;
        if (wr_fire && sel_mask) begin
            mask_next = wbyte[`PTU_ST_W-1:0];
        end
    end

    // Status and mask state
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            status_reg <= `PTU_STATUS_RST;
            mask_reg   <= `PTU_MASK_RST;
        end else begin
            status_reg <= status_next;
            mask_reg   <= mask_next;
        end
    end

    // Read data captured in the waiting cycle, valid when answered
    always @* begin
        rdata_next = rdata_reg;
        if (avs_read && !resp_reg) begin
            rdata_next = 32'h0000_0000;
            if (!locked) begin
                if (sel_control) begin
                    rdata_next[7:0] = control_image(flag_reg, rate_reg,
                                                    irq_en_reg, enable_reg);
                end else if (sel_status) begin
                    rdata_next[`PTU_ST_W-1:0] = status_reg;
                end else if (sel_mask) begin
                    rdata_next[`PTU_ST_W-1:0] = mask_reg;
                end else if (sel_count) begin
                    rdata_next[STAGES-1:0] = div_count;
                end
            end
        end
    end

    // Read data register
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign avs_readdata = rdata_reg;

    // Request stays up as long as flag and irq enable both hold
    assign tick_irq_request = flag_reg & irq_en_reg; // RULE_04 RULE_18

    // Periodic wakeup path out of stop
    assign stop_wakeup = tick_irq_request & stop_mode & oscillator_run_in_stop; // RULE_15

    // System interrupt level from unmasked sticky bits
    assign irq = |(status_reg & mask_reg);

endmodule // ptu_periodic_tick_unit

// file: hdl/ptu_regs.vh
// Register map, field positions, reset values and divider taps of the tick unit
`ifndef PTU_REGS_VH
`define PTU_REGS_VH

// Byte offsets on the Avalon slave
`define PTU_OFS_CONTROL   4'h0
`define PTU_OFS_STATUS    4'h4
`define PTU_OFS_MASK      4'h8
`define PTU_OFS_COUNT     4'hC
`define PTU_ADDR_W        4

// Fields of timebase_control
`define PTU_BIT_ENABLE    1
`define PTU_BIT_IRQ_EN    2
`define PTU_BIT_ACK       3
`define PTU_RATE_LSB      4
`define PTU_RATE_MSB      6
`define PTU_BIT_FLAG      7
`define PTU_CONTROL_RST   8'h00

// Fields of interrupt status and mask
`define PTU_ST_TICK       0
`define PTU_ST_BLOCKED    1
`define PTU_ST_MISSED     2
`define PTU_ST_W          3
`define PTU_STATUS_RST    3'h0
`define PTU_MASK_RST      3'h0

// Divider chain and intended source rate
`define PTU_STAGES        15
`define PTU_TAP_W         4
`define PTU_SRC_HZ        32768

// Tap bit per rate code; the tap rises first after half a period
`define PTU_TAP_R0        4'hE
`define PTU_TAP_R1        4'hC
`define PTU_TAP_R2        4'hA
`define PTU_TAP_R3        4'h6
`define PTU_TAP_R4        4'h5
`define PTU_TAP_R5        4'h4
`define PTU_TAP_R6        4'h3
`define PTU_TAP_R7        4'h2

`endif

// file: hdl/ptu_divider.v
// Fifteen stage divider chain with a selectable rising-tap strobe
`timescale 1ns/1ps
module ptu_divider #(
    parameter STAGES = 15,
    parameter TAP_W  = 4
) (
    input  wire              clk_sys,
    input  wire              reset,
    input  wire              run,
    input  wire              clear,
    input  wire [TAP_W-1:0]  tap_sel,
    output wire [STAGES-1:0] count,
    output wire              tap_event
);

    reg  [STAGES-1:0] count_reg;
    wire [STAGES-1:0] count_next;
    wire [STAGES-1:0] count_plus;

    // Increment wraps across all stages
    assign count_plus = count_reg + {{(STAGES-1){1'b0}}, 1'b1};

    // Clear dominates so a disabled chain never drifts
    assign count_next = clear ? {STAGES{1'b0}} :
                        run   ? count_plus : count_reg;

    // Chain state
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            count_reg <= {STAGES{1'b0}};
        end else begin
            count_reg <= count_next;
        end
    end

    // Strobe when the chosen stage goes from zero to one
    assign tap_event = run & ~clear & ~count_reg[tap_sel] & count_plus[tap_sel];
    assign count     = count_reg;

endmodule // ptu_divider

// file: test/ptu_checker.sv
// Bus and tick output assertions for the periodic tick unit
`timescale 1ns/1ps
module ptu_checker (
    input wire        clk_sys,
    input wire        reset,
    input wire [3:0]  avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0]  avs_byteenable,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest,
    input wire        wait_mode,
    input wire        stop_mode,
    input wire        oscillator_run_in_stop,
    input wire        tick_irq_request,
    input wire        stop_wakeup
);
    reg       en_sh;
    reg [1:0] frz;
    wire      lock = wait_mode | stop_mode;
    wire      wr0  = avs_write & ~avs_waitrequest & (avs_address == 4'h0);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Enable shadow; locked writes never reach it
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            en_sh <= 1'b0;
            frz   <= 2'h0;
        end else begin
            if (wr0 & avs_byteenable[0] & ~lock)
                en_sh <= avs_writedata[1];
            frz <= {frz[0], stop_mode & ~oscillator_run_in_stop};
        end
    end
    a_wait_one: assert property ((avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest longer than one cycle");
    a_idle_nowait: assert property (!(avs_read | avs_write) |-> !avs_waitrequest)
        else $error("waitrequest without request");
    a_rdata_hold: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
        else $error("readdata changed without read");
    a_ack_read0: assert property (
        avs_read && !avs_waitrequest && avs_address == 4'h0 |-> !avs_readdata[3])
        else $error("ack bit read as one");
    a_count_zero: assert property (
        !en_sh && avs_read && !avs_waitrequest && avs_address == 4'hC |->
        avs_readdata == 32'h0)
        else $error("count not zero while disabled");
    a_locked_read: assert property (
        lock && $past(lock) && avs_read && !avs_waitrequest |-> avs_readdata == 32'h0)
        else $error("locked read returned data");
    a_hold_req: assert property (tick_irq_request && !wr0 |=> tick_irq_request)
        else $error("request dropped without control write");
    a_stop_frozen: assert property (
        frz == 2'h3 && stop_mode && !oscillator_run_in_stop |-> $stable(tick_irq_request))
        else $error("request moved in frozen stop");
    a_wake_eq: assert property (
        stop_wakeup == (tick_irq_request && stop_mode && oscillator_run_in_stop))
        else $error("wakeup level wrong");
endmodule // ptu_checker

bind ptu_periodic_tick_unit ptu_checker u_chk (.clk_sys(clk_sys), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .wait_mode(wait_mode),
    .stop_mode(stop_mode), .oscillator_run_in_stop(oscillator_run_in_stop),
    .tick_irq_request(tick_irq_request), .stop_wakeup(stop_wakeup));

// file: test/tb.sv
// Self-checking bench for the periodic tick unit
`timescale 1ns/1ps
module tb;
    reg         clk_sys, reset, avs_read, avs_write, crystal_input;
    reg         wait_mode, stop_mode, oscillator_run_in_stop, xt_run;
    reg  [3:0]  avs_address, avs_byteenable;
    reg  [31:0] avs_writedata, q;
    wire [31:0] avs_readdata;
    wire        avs_waitrequest, tick_irq_request, stop_wakeup, irq;
    integer     num_errors, n_checks, xe, s, r, i;

    ptu_periodic_tick_unit u_dut (.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .crystal_input(crystal_input),
        .wait_mode(wait_mode), .stop_mode(stop_mode),
        .oscillator_run_in_stop(oscillator_run_in_stop),
        .tick_irq_request(tick_irq_request), .stop_wakeup(stop_wakeup), .irq(irq));

    // Clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Crystal at one eighth of the bus rate, gated so edge counts start exact
    always begin
        repeat (4) @(posedge clk_sys);
        if (xt_run) crystal_input <= ~crystal_input;
    end
    always @(posedge crystal_input) xe = xe + 1;

    task stop_test;
        begin
            $display("checks %0d errors %0d", n_checks, num_errors);
            if (num_errors == 0 && n_checks > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    task cmp_w(input [31:0] g, input [31:0] e);
        begin
            n_checks = n_checks + 1;
            if (g !== e) begin
                num_errors = num_errors + 1;
                $display("[ERR] %0t word %h expected %h", $time, g, e);
            end
        end
    endtask
    task cmp_b(input g, input e);
        begin
            n_checks = n_checks + 1;
            if (g !== e) begin
                num_errors = num_errors + 1;
                $display("[ERR] %0t bit %b expected %b", $time, g, e);
            end
        end
    endtask
    // One Avalon transfer; waitrequest and read data taken at the rising edge
    task bus(input wr, input [3:0] a, input [31:0] d);
        integer k;
        begin
            @(posedge clk_sys);
            avs_address <= a;
            avs_writedata <= d;
            avs_write <= wr;
            avs_read <= ~wr;
            k = 0;
            @(posedge clk_sys);
            while (avs_waitrequest !== 1'b0 && k < 20) begin
                @(posedge clk_sys);
                k = k + 1;
            end
            if (k == 20) begin
                num_errors = num_errors + 1;
                $display("[ERR] %0t bus hang", $time);
                stop_test;
            end
            q = avs_readdata;
            avs_read <= 1'b0;
            avs_write <= 1'b0;
            // Leave mid-cycle so bench-side flags never race the crystal process
            @(negedge clk_sys);
        end
    endtask
    task rd(input [3:0] a, input [31:0] e);
        begin
            bus(1'b0, a, 32'h0);
            cmp_w(q, e);
        end
    endtask
    // Bounded wait for the tick request
    task wt;
        integer k;
        begin
            for (k = 0; k < 3000 && tick_irq_request !== 1'b1; k = k + 1) @(posedge clk_sys);
            if (k == 3000) begin
                num_errors = num_errors + 1;
                $display("[ERR] %0t no tick", $time);
                stop_test;
            end
        end
    endtask
    function integer tap(input integer c);
        tap = (c >= 3) ? 9 - c : 14 - 2 * c;
    endfunction

    // Main sequence
    initial begin
        {avs_read, avs_write, crystal_input, wait_mode, stop_mode} = 5'h00;
        {oscillator_run_in_stop, xt_run} = 2'h0;
        avs_address = 4'h0;
        avs_byteenable = 4'hF;
        avs_writedata = 32'h0;
        {num_errors, n_checks, xe} = 96'h0;
        i = $urandom(88590);
        reset = 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        rd(4'h0, 32'h0);
        rd(4'hC, 32'h0);
        rd(4'h4, 32'h0);
        rd(4'h8, 32'h0);
        rd(4'h2, 32'h0);
        $display("reset test done");
        // Random control images, enable kept clear
        for (i = 0; i < 6; i = i + 1) begin
            s = ($urandom & 8'hF5) | 8'h08;
            bus(1'b1, 4'h0, s);
            rd(4'h0, s & 8'h74);
        end
        rd(4'hC, 32'h0);
        $display("control test done");
        // Every fast rate: half period first, full period next
        for (r = 3; r < 8; r = r + 1) begin
            xt_run = 1'b0;
            bus(1'b1, 4'h0, 8'h08);
            bus(1'b1, 4'h0, 8'h0E | (r << 4));
            s = xe;
            xt_run = 1'b1;
            wt;
            cmp_w(xe - s, 1 << tap(r));
            s = xe;
            cmp_b(irq, 1'b0);
            rd(4'h0, 8'h86 | (r << 4));
            bus(1'b1, 4'h0, 8'h0E | (r << 4));
            cmp_b(tick_irq_request, 1'b0);
            wt;
            cmp_w(xe - s, 2 << tap(r));
        end
        $display("rate test done");
        // Sticky flag, status, mask and level interrupt
        repeat (200) @(posedge clk_sys);
        cmp_b(tick_irq_request, 1'b1);
        bus(1'b1, 4'h0, 8'h72);
        cmp_b(tick_irq_request, 1'b0);
        rd(4'h4, 32'h5);
        bus(1'b1, 4'h8, 32'h1);
        cmp_b(irq, 1'b1);
        bus(1'b1, 4'h0, 8'h08);
        bus(1'b1, 4'h4, 32'h7);
        rd(4'h4, 32'h0);
        cmp_b(irq, 1'b0);
        $display("interrupt test done");
        // Wait mode: register locked, counting goes on
        bus(1'b1, 4'h0, 8'h7E);
        @(posedge clk_sys) wait_mode <= 1'b1;
        rd(4'h0, 32'h0);
        bus(1'b1, 4'h0, 8'h08);
        wt;
        cmp_b(tick_irq_request, 1'b1);
        @(posedge clk_sys) wait_mode <= 1'b0;
        bus(1'b0, 4'h4, 32'h0);
        cmp_w(q & 32'h3, 32'h3);
        $display("wait test done");
        // Stop mode without, then with, the oscillator kept alive
        xt_run = 1'b0;
        bus(1'b1, 4'h0, 8'h7E);
        @(posedge clk_sys) stop_mode <= 1'b1;
        xt_run = 1'b1;
        repeat (300) @(posedge clk_sys);
        cmp_b(tick_irq_request, 1'b0);
        @(posedge clk_sys) oscillator_run_in_stop <= 1'b1;
        wt;
        cmp_b(stop_wakeup, 1'b1);
        @(posedge clk_sys) stop_mode <= 1'b0;
        $display("stop test done");
        stop_test;
    end
endmodule // tb
